// >>> hw/los_thr_pkg.sv
// What this block does
// RULE1: rx2 below low threshold sets low alarm
// RULE2: alarm holds until above high; then high
// RULE3: rx2 high threshold, eight bits, offset ba
// RULE4: rx2 low threshold, eight bits, offset bb
// RULE5: reads need factory, or user plus grant
// RULE6: threshold writes need fast compare off, password
// RULE7: ranging writes need password, ignore fast compare
// RULE8: three registers reset 00h, shared by both
// RULE9: offset b9 reserved, reads 00h
// RULE10: ranging bits 6:4 high, 2:0 low
// RULE11: ranging codes scale 1.25 v full scale
// RULE12: level equals code over 256 times scale
package los_thr_pkg;
   // register offsets
   localparam logic [7:0] RESERVED_B9_OFS = 8'hb9;
   localparam logic [7:0] RX2_HIGH_THR_OFS = 8'hba;
   localparam logic [7:0] RX2_LOW_THR_OFS = 8'hbb;
   localparam logic [7:0] RX1_RANGE_OFS = 8'hbc;
   // factory values
   localparam logic [7:0] THR_RESET = 8'h00;
   localparam logic [7:0] RANGE_RESET = 8'h00;
   localparam logic [7:0] RESERVED_VALUE = 8'h00;
   // ranging field layout
   localparam int RANGE_HIGH_LSB = 4;
   localparam int RANGE_LOW_LSB = 0;
   localparam logic [7:0] RANGE_WRITE_MASK = 8'h77;
   // full scale per ranging code, in units of 0.1 mv
   localparam logic [13:0] FS_CODE0 = 14'd12500;
   localparam logic [13:0] FS_CODE1 = 14'd10003;
   localparam logic [13:0] FS_CODE2 = 14'd8336;
   localparam logic [13:0] FS_CODE3 = 14'd6256;
   localparam logic [13:0] FS_CODE4 = 14'd5006;
   localparam logic [13:0] FS_CODE5 = 14'd4172;
   localparam logic [13:0] FS_CODE6 = 14'd3578;
   localparam logic [13:0] FS_CODE7 = 14'd3130;
   // threshold code divisor is 2^8
   localparam int THR_FRAC_BITS = 8;
endpackage

// >>> hw/los_threshold_ranging_regs.sv
`timescale 1ns/1ps
module los_threshold_ranging_regs (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // byte access port from the serial interface engine
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata_ff,
   output logic reg_rd_valid_ff,
   output logic reg_denied_ff,
   // security and mode levels
   input wire logic user_password_level,
   input wire logic factory_password_level,
   input wire logic table_two_rw_grant,
   input wire logic table_two_read_grant,
   input wire logic fast_compare_enable,
   // receiver two comparator
   input wire logic [7:0] rx2_signal_strength,
   output logic rx2_los_low_alarm_ff,
   output logic rx2_los_high_alarm_ff,
   // register contents to the analog side
   output logic [7:0] rx2_high_threshold_ff,
   output logic [7:0] rx2_low_threshold_ff,
   output logic [2:0] rx1_high_range_select_ff,
   output logic [2:0] rx1_low_range_select_ff,
   // receiver one threshold codes and resulting levels (0.1 mv units)
   input wire logic [7:0] rx1_high_threshold_code,
   input wire logic [7:0] rx1_low_threshold_code,
   output logic [13:0] rx1_high_level_ff,
   output logic [13:0] rx1_low_level_ff
);

   ////////////////////////////////////////////////////////////////////////////
   // helper functions

   // full scale for a ranging code
   function automatic logic [13:0] full_scale(input logic [2:0] code);
      logic [13:0] fs;
      fs = los_thr_pkg::FS_CODE0;
      unique case (code) // see RULE11
         3'h0: fs = los_thr_pkg::FS_CODE0;
         3'h1: fs = los_thr_pkg::FS_CODE1;
         3'h2: fs = los_thr_pkg::FS_CODE2;
         3'h3: fs = los_thr_pkg::FS_CODE3;
         3'h4: fs = los_thr_pkg::FS_CODE4;
         3'h5: fs = los_thr_pkg::FS_CODE5;
         3'h6: fs = los_thr_pkg::FS_CODE6;
         3'h7: fs = los_thr_pkg::FS_CODE7;
      endcase
      return fs;
   endfunction

   // comparison level from threshold code and range
   function automatic logic [13:0] level(input logic [7:0] thr, input logic [2:0] code);
      logic [21:0] prod;
      prod = 22'(thr) * 22'(full_scale(code));
      return prod[21:los_thr_pkg::THR_FRAC_BITS]; // see RULE12
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // access permission

   logic read_ok; // read allowed
   logic write_ok; // write allowed, before fast compare gating

   always_comb begin
      read_ok = factory_password_level |
         (user_password_level & (table_two_rw_grant | table_two_read_grant)); // see RULE5
      write_ok = factory_password_level | (user_password_level & table_two_rw_grant); // see RULE6 see RULE7
   end

   ////////////////////////////////////////////////////////////////////////////
   // register storage

   logic [7:0] nxt_rx2_high_threshold; // next high threshold
   logic [7:0] nxt_rx2_low_threshold; // next low threshold
   logic [7:0] range_ff; // ranging register, reserved bits held zero
   logic [7:0] nxt_range; // next ranging value
   logic thr_wr_ok; // threshold write accepted

   // write decode
   always_comb begin
      thr_wr_ok = reg_wr & write_ok & ~fast_compare_enable; // see RULE6
      nxt_rx2_high_threshold = rx2_high_threshold_ff;
      nxt_rx2_low_threshold = rx2_low_threshold_ff;
      nxt_range = range_ff;
      if (thr_wr_ok && reg_addr == los_thr_pkg::RX2_HIGH_THR_OFS) begin
         nxt_rx2_high_threshold = reg_wdata; // see RULE3
      end
      if (thr_wr_ok && reg_addr == los_thr_pkg::RX2_LOW_THR_OFS) begin
         nxt_rx2_low_threshold = reg_wdata; // see RULE4
      end
      // fast compare does not block ranging writes
      if (reg_wr && write_ok && reg_addr == los_thr_pkg::RX1_RANGE_OFS) begin
         nxt_range = reg_wdata & los_thr_pkg::RANGE_WRITE_MASK; // see RULE7 see RULE10
      end
   end

   // register the storage, factory values after reset
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx2_high_threshold_ff <= los_thr_pkg::THR_RESET; // see RULE8
         rx2_low_threshold_ff <= los_thr_pkg::THR_RESET;
         range_ff <= los_thr_pkg::RANGE_RESET;
      end else begin
         rx2_high_threshold_ff <= nxt_rx2_high_threshold;
         rx2_low_threshold_ff <= nxt_rx2_low_threshold;
         range_ff <= nxt_range;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read path

   logic [7:0] nxt_reg_rdata; // next read data
   logic nxt_reg_denied; // next denied flag

   // read mux, zero when refused or unmapped
   always_comb begin
      nxt_reg_rdata = 8'h00;
      nxt_reg_denied = 1'b0;
      if (reg_rd && !read_ok) begin
         nxt_reg_denied = 1'b1; // see RULE5
      end else if (reg_rd) begin
         unique case (reg_addr)
            los_thr_pkg::RESERVED_B9_OFS: nxt_reg_rdata = los_thr_pkg::RESERVED_VALUE; // see RULE9
            los_thr_pkg::RX2_HIGH_THR_OFS: nxt_reg_rdata = rx2_high_threshold_ff;
            los_thr_pkg::RX2_LOW_THR_OFS: nxt_reg_rdata = rx2_low_threshold_ff;
            los_thr_pkg::RX1_RANGE_OFS: nxt_reg_rdata = range_ff;
            default: nxt_reg_rdata = 8'h00;
         endcase
      end
   end

   // register the read answer
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_ff <= 8'h00;
         reg_rd_valid_ff <= 1'b0;
         reg_denied_ff <= 1'b0;
      end else begin
         reg_rdata_ff <= nxt_reg_rdata;
         reg_rd_valid_ff <= reg_rd;
         reg_denied_ff <= nxt_reg_denied;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver two hysteresis comparator

   logic nxt_low_alarm; // next low alarm
   logic nxt_high_alarm; // next high alarm
   logic below_low; // strength under low threshold
   logic above_high; // strength over high threshold

   // below low wins if the thresholds overlap
   always_comb begin
      below_low = rx2_signal_strength < rx2_low_threshold_ff;
      above_high = rx2_signal_strength > rx2_high_threshold_ff;
      nxt_low_alarm = rx2_los_low_alarm_ff;
      nxt_high_alarm = rx2_los_high_alarm_ff;
      if (below_low) begin
         nxt_low_alarm = 1'b1; // see RULE1
         nxt_high_alarm = 1'b0;
      end else if (above_high) begin
         nxt_low_alarm = 1'b0; // see RULE2
         nxt_high_alarm = 1'b1;
      end
   end

   // register the alarms
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx2_los_low_alarm_ff <= 1'b0;
         rx2_los_high_alarm_ff <= 1'b0;
      end else begin
         rx2_los_low_alarm_ff <= nxt_low_alarm;
         rx2_los_high_alarm_ff <= nxt_high_alarm;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receiver one ranging and levels

   logic [2:0] nxt_high_sel; // high range field
   logic [2:0] nxt_low_sel; // low range field
   logic [13:0] nxt_high_level; // next high level
   logic [13:0] nxt_low_level; // next low level

   // split the fields and scale the thresholds
   always_comb begin
      nxt_high_sel = range_ff[los_thr_pkg::RANGE_HIGH_LSB +: 3]; // see RULE10
      nxt_low_sel = range_ff[los_thr_pkg::RANGE_LOW_LSB +: 3];
      nxt_high_level = level(rx1_high_threshold_code, range_ff[los_thr_pkg::RANGE_HIGH_LSB +: 3]); // see RULE12
      nxt_low_level = level(rx1_low_threshold_code, range_ff[los_thr_pkg::RANGE_LOW_LSB +: 3]);
   end

   // register fields and levels
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         rx1_high_range_select_ff <= 3'h0;
         rx1_low_range_select_ff <= 3'h0;
         rx1_high_level_ff <= 14'h0000;
         rx1_low_level_ff <= 14'h0000;
      end else begin
         rx1_high_range_select_ff <= nxt_high_sel;
         rx1_low_range_select_ff <= nxt_low_sel;
         rx1_high_level_ff <= nxt_high_level;
         rx1_low_level_ff <= nxt_low_level;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   low_alarm_set_a: assert property ( // see RULE1
      @(posedge ref_clk) disable iff (!rst_b)
      (rx2_signal_strength < rx2_low_threshold_ff) |=> rx2_los_low_alarm_ff && !rx2_los_high_alarm_ff)
      else $error("low alarm not set below low threshold");

   high_alarm_set_a: assert property ( // see RULE2
      @(posedge ref_clk) disable iff (!rst_b)
      (rx2_signal_strength >= rx2_low_threshold_ff && rx2_signal_strength > rx2_high_threshold_ff)
      |=> rx2_los_high_alarm_ff && !rx2_los_low_alarm_ff)
      else $error("high alarm not set above high threshold");

   alarm_hold_a: assert property ( // see RULE2
      @(posedge ref_clk) disable iff (!rst_b)
      (rx2_signal_strength >= rx2_low_threshold_ff && rx2_signal_strength <= rx2_high_threshold_ff)
      |=> $stable(rx2_los_low_alarm_ff) && $stable(rx2_los_high_alarm_ff))
      else $error("alarm moved inside hysteresis band");

   high_thr_write_a: assert property ( // see RULE3
      @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == 8'hba && factory_password_level && !fast_compare_enable)
      |=> rx2_high_threshold_ff == $past(reg_wdata))
      else $error("high threshold write lost");

   low_thr_write_a: assert property ( // see RULE4
      @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == 8'hbb && user_password_level && table_two_rw_grant && !fast_compare_enable)
      |=> rx2_low_threshold_ff == $past(reg_wdata))
      else $error("low threshold write lost");

   fast_cmp_block_a: assert property ( // see RULE6
      @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && fast_compare_enable) |=> $stable(rx2_high_threshold_ff) && $stable(rx2_low_threshold_ff))
      else $error("threshold changed while fast compare on");

   range_write_a: assert property ( // see RULE7
      @(posedge ref_clk) disable iff (!rst_b)
      (reg_wr && reg_addr == 8'hbc && factory_password_level && fast_compare_enable)
      |=> ##1 rx1_high_range_select_ff == $past(reg_wdata[6:4], 2) && rx1_low_range_select_ff == $past(reg_wdata[2:0], 2))
      else $error("ranging write not taken");

   read_deny_a: assert property ( // see RULE5
      @(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && !factory_password_level && !user_password_level)
      |=> reg_denied_ff && reg_rdata_ff == 8'h00 && reg_rd_valid_ff)
      else $error("read not refused without password");

   reserved_read_a: assert property ( // see RULE9
      @(posedge ref_clk) disable iff (!rst_b)
      (reg_rd && reg_addr == 8'hb9) |=> reg_rdata_ff == 8'h00)
      else $error("reserved location read nonzero");

   full_scale_a: assert property ( // see RULE11
      @(posedge ref_clk) disable iff (!rst_b)
      (range_ff[los_thr_pkg::RANGE_HIGH_LSB +: 3] == 3'h0 && rx1_high_threshold_code == 8'h80)
      |=> rx1_high_level_ff == 14'd6250)
      else $error("full scale level wrong for default code");

endmodule

// >>> dv/host_bus_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// host side of the byte access port
module host_bus_model (
   // clock
   input wire logic ref_clk,
   // requests
   output logic [7:0] reg_addr,
   output logic reg_wr,
   output logic [7:0] reg_wdata,
   output logic reg_rd,
   // answers
   input wire logic [7:0] reg_rdata_ff,
   input wire logic reg_rd_valid_ff,
   input wire logic reg_denied_ff
);
   // idle bus at time zero
   initial begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
   end
   // one byte write; released lines show the inverse pattern
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // one byte read; answer is sampled half a cycle after the taking edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic den, output logic vld);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata_ff;
      den = reg_denied_ff;
      vld = reg_rd_valid_ff;
   endtask
endmodule

// >>> dv/test_los_threshold_ranging_regs.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; $display("ERROR %0t got %h want %h", $time, a, b); end end
////////////////////////////////////////////////////////////
module test_los_threshold_ranging_regs;
   // stimulus and observed signals
   logic ref_clk = 1'b0, rst_b = 1'b0, user = 1'b0, factory = 1'b0, rwg = 1'b0, rdg = 1'b0, fast = 1'b0;
   logic [7:0] strength = 8'h00, hcode = 8'h00, lcode = 8'h00, addr, wdata, rdata, d, cur, bb;
   logic wr, rd, vld, den, low, high, dn, v;
   logic [7:0] hthr, lthr;
   logic [2:0] hsel, lsel;
   logic [13:0] hlvl, llvl;
   int n_errors = 0, compares = 0;
   // full scale per code, 0.1 mv units
   logic [13:0] fs [8] = '{los_thr_pkg::FS_CODE0, los_thr_pkg::FS_CODE1, los_thr_pkg::FS_CODE2,
      los_thr_pkg::FS_CODE3, los_thr_pkg::FS_CODE4, los_thr_pkg::FS_CODE5, los_thr_pkg::FS_CODE6, los_thr_pkg::FS_CODE7};
   always #25 ref_clk = ~ref_clk;
   host_bus_model host (.ref_clk(ref_clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
      .reg_rdata_ff(rdata), .reg_rd_valid_ff(vld), .reg_denied_ff(den));
   los_threshold_ranging_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(addr), .reg_wr(wr),
      .reg_wdata(wdata), .reg_rd(rd), .reg_rdata_ff(rdata), .reg_rd_valid_ff(vld), .reg_denied_ff(den),
      .user_password_level(user), .factory_password_level(factory), .table_two_rw_grant(rwg),
      .table_two_read_grant(rdg), .fast_compare_enable(fast), .rx2_signal_strength(strength),
      .rx2_los_low_alarm_ff(low), .rx2_los_high_alarm_ff(high), .rx2_high_threshold_ff(hthr),
      .rx2_low_threshold_ff(lthr), .rx1_high_range_select_ff(hsel), .rx1_low_range_select_ff(lsel),
      .rx1_high_threshold_code(hcode), .rx1_low_threshold_code(lcode), .rx1_high_level_ff(hlvl),
      .rx1_low_level_ff(llvl));
   // expected level: code over 256 times full scale, truncated
   function automatic logic [13:0] lvl(input logic [2:0] c, input logic [7:0] k);
      logic [31:0] p;
      p = {18'h0, fs[c]} * {24'h0, k};
      return p[21:8];
   endfunction
   // verdict and end of run
   task automatic close_out();
      if (n_errors == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // factory values of every location
   task automatic t_reset();
      for (int a = 8'hb9; a <= 8'hbc; a++) begin
         host.rd(8'(a), d, dn, v);
         `CHK({v, d}, 9'h100)
      end
   endtask
   // plain writes, reserved bits and reserved slot
   task automatic t_basic();
      host.wr(8'hba, 8'h5a);
      host.wr(8'hbb, 8'h3c);
      host.wr(8'hbc, 8'hff);
      host.wr(8'hb9, 8'ha5);
      host.rd(8'hba, d, dn, v);
      `CHK(d, 8'h5a)
      host.rd(8'hbb, d, dn, v);
      `CHK(d, 8'h3c)
      host.rd(8'hbc, d, dn, v);
      `CHK(d, 8'h77)
      `CHK({hsel, lsel}, 6'h3f)
      host.rd(8'hb9, d, dn, v);
      `CHK(d, 8'h00)
      bb = 8'h3c;
      cur = 8'h5a;
   endtask
   // every password and grant combination
   task automatic t_access();
      logic okr, okw;
      for (int i = 0; i < 16; i++) begin
         {factory, user, rwg, rdg} = 4'(i);
         okw = factory | (user & rwg);
         okr = okw | (user & rdg);
         host.wr(8'hba, {4'ha, 4'(i)});
         host.wr(8'hbc, {5'h00, 3'(i)});
         if (okw) cur = {4'ha, 4'(i)};
         host.rd(8'hba, d, dn, v);
         `CHK(dn, !okr)
         `CHK(d, okr ? cur : 8'h00)
         `CHK(hthr, cur)
         if (okw) `CHK(lsel, 3'(i))
      end
   endtask
   // fast compare blocks thresholds only
   task automatic t_fast();
      {factory, user, rwg, rdg} = 4'h8;
      fast = 1'b1;
      host.wr(8'hba, 8'h11);
      host.wr(8'hbb, 8'h22);
      host.wr(8'hbc, 8'h25);
      host.rd(8'hbc, d, dn, v);
      `CHK(d, 8'h25)
      `CHK({hthr, lthr}, {cur, bb})
      fast = 1'b0;
   endtask
   // hysteresis walk: high 80h, low 40h
   task automatic t_alarm();
      logic [7:0] s [6] = '{8'h90, 8'h60, 8'h40, 8'h3f, 8'h80, 8'h81};
      logic [1:0] e [6] = '{2'b01, 2'b01, 2'b01, 2'b10, 2'b10, 2'b01};
      // user password with read-write grant, so the low threshold write takes that path
      {factory, user, rwg, rdg} = 4'h6;
      host.wr(8'hba, 8'h80);
      host.wr(8'hbb, 8'h40);
      for (int k = 0; k < 6; k++) begin
         strength = s[k];
         repeat (2) @(negedge ref_clk);
         `CHK({low, high}, e[k])
      end
   endtask
   // every ranging code on both comparisons
   task automatic t_levels();
      hcode = 8'h80;
      lcode = 8'hff;
      for (int c = 0; c < 8; c++) begin
         host.wr(8'hbc, {1'b0, 3'(c), 1'b0, 3'(7 - c)});
         repeat (3) @(negedge ref_clk);
         `CHK(hlvl, lvl(3'(c), 8'h80))
         `CHK(llvl, lvl(3'(7 - c), 8'hff))
      end
   endtask
   // watchdog
   initial begin
      #100us;
      n_errors++;
      close_out();
   end
   // main sequence
   initial begin
      repeat (6) @(negedge ref_clk);
      rst_b = 1'b1;
      factory = 1'b1;
      t_reset();
      t_basic();
      t_access();
      t_fast();
      t_alarm();
      t_levels();
      close_out();
   end
endmodule
